/* File: rtl/csd_pkg.sv */
// package for the chip-select address decoder
// assumes one 20 MHz clock and a bus master that starts one cycle at a time
package csd_pkg;
    localparam int NUM_CS = 8;
    localparam int NUM_DRAM = 2;
    localparam int ADDR_W = 32;
    localparam int ATTR_W = 4;
    localparam int BE_W = 4;
    // window config field layout (base, mask, attribute, enables)
    localparam int CFG_PORT_W = 2;
    localparam logic [1:0] PORT_32 = 2'h0;
    localparam logic [1:0] PORT_8 = 2'h1;
    localparam logic [1:0] PORT_16 = 2'h2;
    localparam logic [ADDR_W-1:0] BASE_RST = 32'h00000000;
    localparam logic [ADDR_W-1:0] MASK_RST = 32'h00000000;
    localparam int BCLK_DIV = 2;

    typedef struct packed {
        logic valid;
        logic [ADDR_W-1:0] base;
        logic [ADDR_W-1:0] mask;
        logic [ATTR_W-1:0] attr;
        logic [ATTR_W-1:0] attr_mask;
        logic burst_en;
        logic auto_ack;
        logic [CFG_PORT_W-1:0] port;
    } csd_win_type;

    typedef struct packed {
        logic burst_en;
        logic auto_ack;
        logic [CFG_PORT_W-1:0] port;
    } csd_cyc_type;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_WAIT_LOW = 2'b01,
        ST_ACTIVE = 2'b11,
        ST_END_LOW = 2'b10
    } csd_state_type;
endpackage

/* File: rtl/csd_win_match.sv */
// one address window comparator
// assumes window config is stable while a cycle is being decoded
`timescale 1ns/10ps
module csd_win_match (
    input wire csd_pkg::csd_win_type cfg, // window settings
    input wire logic [csd_pkg::ADDR_W-1:0] addr, // cycle address
    input wire logic [csd_pkg::ATTR_W-1:0] attr, // cycle attributes
    output logic hit // window matches
);
    // masked bits of the address are don't-care
    always_comb begin
        hit = cfg.valid
            && (((addr ^ cfg.base) & ~cfg.mask) == '0)
            && (((attr ^ cfg.attr) & cfg.attr_mask) == '0);
    end
endmodule

/* File: rtl/csd_decode.sv */
// chip-select and dram block decode for external bus cycles
// assumes window configs come from a settings block as plain inputs
// and the bus master holds address and attributes during the cycle
`timescale 1ns/10ps
// Function
// R1: compare address against all ten windows
// R2: single hit asserts select, uses its config
// R3: no hit: burst-inhibited, external ack, 32-bit
// R4: multi cs hit: drive all, default cycle
// R5: software avoids dram overlaps; result undefined
// R6: strobe changes only in bus clock low
module csd_decode (
    input wire logic CLK, // 20 MHz clock
    input wire logic RST_N, // async reset, active low
    input wire logic START, // one-cycle bus cycle start pulse
    input wire logic END_CYC, // one-cycle bus cycle end pulse
    input wire logic WRITE, // cycle is a write
    input wire logic [csd_pkg::ADDR_W-1:0] ADDR, // cycle address
    input wire logic [csd_pkg::ATTR_W-1:0] ATTR, // cycle attributes
    input wire logic [csd_pkg::BE_W-1:0] BYTE_EN, // active bytes, high
    input wire csd_pkg::csd_win_type [csd_pkg::NUM_CS-1:0]
        SELECT_WINDOW_CONFIG, // chip-select windows
    input wire csd_pkg::csd_win_type DRAM_WINDOW0_CONFIG, // dram block 0
    input wire csd_pkg::csd_win_type DRAM_WINDOW1_CONFIG, // dram block 1
    output logic BUS_CLOCK_OUT, // bus clock output
    output logic ADDR_STROBE_N, // address strobe, active low
    output logic [csd_pkg::NUM_CS-1:0] CS_N, // chip selects, active low
    output logic [csd_pkg::BE_W-1:0]
        BYTE_LANE_WRITE_ENABLES_N, // byte enables, active low
    output logic OE_N, // output enable, active low
    output logic [csd_pkg::NUM_DRAM-1:0] DRAM_SEL, // dram block select
    output csd_pkg::csd_cyc_type CYC_CFG, // settings used by cycle
    output logic CYC_VALID // decode result held for cycle
);
    typedef struct packed {
        csd_pkg::csd_state_type st;
        logic bclk;
        logic pend_end;
        logic as_n;
        logic [csd_pkg::NUM_CS-1:0] cs_n;
        logic [csd_pkg::BE_W-1:0] be_n;
        logic oe_n;
        logic [csd_pkg::NUM_CS-1:0] cs_hit;
        logic [csd_pkg::BE_W-1:0] be_hold;
        logic wr;
        logic [csd_pkg::NUM_DRAM-1:0] dsel;
        csd_pkg::csd_cyc_type cyc;
        logic cvalid;
    } csd_regs_type;

    csd_regs_type state_reg;
    csd_regs_type state_next;
    logic [csd_pkg::NUM_CS-1:0] cs_match;
    logic [csd_pkg::NUM_DRAM-1:0] dram_match;
    csd_pkg::csd_win_type dram_cfg [csd_pkg::NUM_DRAM];
    csd_pkg::csd_cyc_type win_cyc;
    csd_pkg::csd_cyc_type dflt_cyc;

    assign dram_cfg[0] = DRAM_WINDOW0_CONFIG;
    assign dram_cfg[1] = DRAM_WINDOW1_CONFIG;

    // one-cycle enable: the bus clock falls at the coming edge
    logic low_phase_en;
    assign low_phase_en = state_reg.bclk;

    // a start is taken only while idle; one while busy is ignored
    logic start_take;
    assign start_take = START && (state_reg.st == csd_pkg::ST_IDLE);

    genvar gi;
    generate
        for (gi = 0; gi < csd_pkg::NUM_CS; gi++) begin : g_cs
            csd_win_match u_cs (
                .cfg(SELECT_WINDOW_CONFIG[gi]),
                .addr(ADDR),
                .attr(ATTR),
                .hit(cs_match[gi])
            ); // R1
        end
        for (gi = 0; gi < csd_pkg::NUM_DRAM; gi++) begin : g_dr
            csd_win_match u_dr (
                .cfg(dram_cfg[gi]),
                .addr(ADDR),
                .attr(ATTR),
                .hit(dram_match[gi])
            ); // R1
        end
    endgenerate

    // lowest-index dram block wins; overlaps are undefined anyway
    logic [csd_pkg::NUM_DRAM-1:0] dram_pick;
    logic cs_single;
    always_comb begin
        dram_pick = '0;
        for (int i = csd_pkg::NUM_DRAM - 1; i >= 0; i--) begin
            if (dram_match[i]) begin
                dram_pick = '0;
                dram_pick[i] = 1'b1;
            end
        end
        cs_single = ($countones(cs_match) == 1);
    end

    // default: no burst, external termination, 32-bit port
    always_comb begin
        dflt_cyc.burst_en = 1'b0;
        dflt_cyc.auto_ack = 1'b0;
        dflt_cyc.port = csd_pkg::PORT_32;
    end

    // overlapping dram windows are undefined; lowest index wins here
    always_comb begin
        win_cyc = dflt_cyc; // R3
        if (dram_match[0]) begin
            win_cyc.burst_en = DRAM_WINDOW0_CONFIG.burst_en; // R2 R5
            win_cyc.auto_ack = DRAM_WINDOW0_CONFIG.auto_ack;
            win_cyc.port = DRAM_WINDOW0_CONFIG.port;
        end else if (dram_match[1]) begin
            win_cyc.burst_en = DRAM_WINDOW1_CONFIG.burst_en; // R2 R5
            win_cyc.auto_ack = DRAM_WINDOW1_CONFIG.auto_ack;
            win_cyc.port = DRAM_WINDOW1_CONFIG.port;
        end else if (cs_single) begin
            for (int i = 0; i < csd_pkg::NUM_CS; i++) begin
                if (cs_match[i]) begin
                    win_cyc.burst_en = SELECT_WINDOW_CONFIG[i].burst_en; // R2
                    win_cyc.auto_ack = SELECT_WINDOW_CONFIG[i].auto_ack;
                    win_cyc.port = SELECT_WINDOW_CONFIG[i].port;
                end
            end
        end
        // several cs hits keep the default cycle settings R4
    end

    always_comb begin
        state_next = state_reg;
        state_next.bclk = ~state_reg.bclk;
        // remember an end that comes before the strobes
        if (END_CYC && state_reg.st != csd_pkg::ST_IDLE) begin
            state_next.pend_end = 1'b1;
        end
        case (state_reg.st)
            // latch decode and cycle settings when a start is taken
            csd_pkg::ST_IDLE: begin
                if (start_take) begin
                    state_next.cs_hit = (dram_match != '0) ? '0 : cs_match;
                    state_next.dsel = dram_pick; // R2 R5
                    state_next.cyc = win_cyc;
                    state_next.cvalid = 1'b1;
                    state_next.wr = WRITE;
                    state_next.be_hold = BYTE_EN;
                    state_next.pend_end = 1'b0;
                    state_next.st = csd_pkg::ST_WAIT_LOW;
                end
            end

            csd_pkg::ST_WAIT_LOW: begin
                // strobes switch as the bus clock falls, so in its low phase
                if (low_phase_en) begin
                    state_next.as_n = 1'b0; // R6
                    state_next.cs_n = ~state_reg.cs_hit; // R2 R4 R6
                    state_next.be_n = ~state_reg.be_hold; // R6
                    state_next.oe_n = state_reg.wr; // R6
                    state_next.st = csd_pkg::ST_ACTIVE;
                end
            end

            // hold strobes until the far side ends the cycle
            csd_pkg::ST_ACTIVE: begin
                if (END_CYC || state_reg.pend_end) begin
                    state_next.st = csd_pkg::ST_END_LOW;
                end
            end

            // release at the next fall of the bus clock
            csd_pkg::ST_END_LOW: begin
                if (low_phase_en) begin
                    state_next.as_n = 1'b1; // R6
                    state_next.cs_n = '1; // R6
                    state_next.be_n = '1; // R6
                    state_next.oe_n = 1'b1; // R6
                    state_next.dsel = '0;
                    state_next.cvalid = 1'b0;
                    state_next.pend_end = 1'b0;
                    state_next.st = csd_pkg::ST_IDLE;
                end
            end

            default: begin
                state_next.st = csd_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            // strobes idle high, bus clock low, no cycle open
            state_reg.st <= csd_pkg::ST_IDLE;
            state_reg.bclk <= 1'b0;
            state_reg.pend_end <= 1'b0;
            state_reg.as_n <= 1'b1;
            state_reg.cs_n <= '1;
            state_reg.be_n <= '1;
            state_reg.oe_n <= 1'b1;
            state_reg.cs_hit <= '0;
            state_reg.be_hold <= '0;
            state_reg.wr <= 1'b0;
            state_reg.dsel <= '0;
            state_reg.cyc <= '0;
            state_reg.cvalid <= 1'b0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign BUS_CLOCK_OUT = state_reg.bclk;
    assign ADDR_STROBE_N = state_reg.as_n;
    assign CS_N = state_reg.cs_n;
    assign BYTE_LANE_WRITE_ENABLES_N = state_reg.be_n;
    assign OE_N = state_reg.oe_n;
    assign DRAM_SEL = state_reg.dsel;
    assign CYC_CFG = state_reg.cyc;
    assign CYC_VALID = state_reg.cvalid;
endmodule

/* File: bench/csd_checker.sv */
// port checker for the chip-select decoder
// assumes the bind at the foot reaches the top module's ports
`timescale 1ns/10ps
module csd_checker (
    input wire logic CLK, // clock
    input wire logic RST_N, // reset
    input wire logic START, // start pulse
    input wire logic END_CYC, // end pulse
    input wire logic BUS_CLOCK_OUT, // bus clock
    input wire logic ADDR_STROBE_N, // strobe
    input wire logic [csd_pkg::NUM_CS-1:0] CS_N, // selects
    input wire logic [csd_pkg::BE_W-1:0] BYTE_LANE_WRITE_ENABLES_N, // lanes
    input wire logic OE_N, // output enable
    input wire logic [csd_pkg::NUM_DRAM-1:0] DRAM_SEL, // dram select
    input wire csd_pkg::csd_cyc_type CYC_CFG, // cycle settings
    input wire logic CYC_VALID // cycle valid
);
    logic dflt;
    assign dflt = (CYC_CFG == '0);
    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_N);
    sequence s_take;
        START && !CYC_VALID;
    endsequence
    sequence s_drive;
        CYC_VALID ##[0:2] !ADDR_STROBE_N;
    endsequence
    AST_START_DECODE: assert property (s_take |=> s_drive)
        else $error("no strobe after start");
    AST_CS_PHASE: assert property (
        !$stable(CS_N) |-> $fell(BUS_CLOCK_OUT))
        else $error("select moved outside low phase");
    AST_LANE_PHASE: assert property (
        !$stable({BYTE_LANE_WRITE_ENABLES_N, OE_N, ADDR_STROBE_N})
        |-> !BUS_CLOCK_OUT && $past(BUS_CLOCK_OUT))
        else $error("strobe moved outside low phase");
    AST_NO_HIT: assert property (
        (!ADDR_STROBE_N && &CS_N && DRAM_SEL == '0) |-> dflt)
        else $error("miss cycle not default");
    AST_MULTI_HIT: assert property (
        (!ADDR_STROBE_N && $countones(~CS_N) > 1) |-> dflt)
        else $error("multi hit not default");
    AST_ONE_DRAM: assert property (
        CYC_VALID |-> $onehot0(DRAM_SEL) && (DRAM_SEL == '0 || &CS_N))
        else $error("bad dram select");
    AST_END: assert property (
        (END_CYC && !ADDR_STROBE_N) |-> ##[1:3] (ADDR_STROBE_N && !CYC_VALID))
        else $error("cycle not closed");
    AST_IN_CYCLE: assert property (!ADDR_STROBE_N |-> CYC_VALID)
        else $error("strobe outside cycle");
endmodule
bind csd_decode csd_checker chk (.CLK(CLK), .RST_N(RST_N), .START(START),
    .END_CYC(END_CYC), .BUS_CLOCK_OUT(BUS_CLOCK_OUT), .OE_N(OE_N),
    .ADDR_STROBE_N(ADDR_STROBE_N), .CS_N(CS_N), .DRAM_SEL(DRAM_SEL),
    .BYTE_LANE_WRITE_ENABLES_N(BYTE_LANE_WRITE_ENABLES_N),
    .CYC_CFG(CYC_CFG), .CYC_VALID(CYC_VALID));

/* File: bench/csd_peer.sv */
// far-side device: terminates a cycle some cycles after the strobe
// assumes the strobe stays low until termination is seen
`timescale 1ns/10ps
module csd_peer (
    input wire logic clk, // clock
    input wire logic rst_n, // reset
    input wire logic as_n, // strobe
    input wire logic [3:0] wait_cyc, // wait states
    output logic end_cyc // termination pulse
);
    logic [3:0] cnt_reg;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg <= 4'h0;
            end_cyc <= 1'h0;
        end else begin
            end_cyc <= 1'h0;
            if (as_n) cnt_reg <= 4'h0;
            else if (cnt_reg < wait_cyc) cnt_reg <= cnt_reg + 4'h1;
            else if (cnt_reg == wait_cyc) begin
                end_cyc <= 1'h1;
                cnt_reg <= 4'hF;
            end
        end
    end
endmodule

/* File: bench/chip_select_address_decode_bench.sv */
// self-checking bench for the chip-select decoder
// assumes csd_peer terminates cycles and the checker is bound
`timescale 1ns/10ps
module chip_select_address_decode_bench;
    logic CLK = 1'h0, RST_N = 1'h0, START = 1'h0, WRITE = 1'h0, END_CYC;
    logic [31:0] ADDR = 32'h0;
    logic [3:0] ATTR = 4'h0, BYTE_EN = 4'h0, wt = 4'h2, BE_N;
    logic BUS_CLOCK_OUT, ADDR_STROBE_N, OE_N, CYC_VALID;
    logic [7:0] CS_N;
    logic [1:0] DRAM_SEL;
    csd_pkg::csd_win_type [7:0] sw;
    csd_pkg::csd_win_type dw0, dw1;
    csd_pkg::csd_cyc_type CYC_CFG;
    int n_mismatch = 0, checked = 0;
    always #25 CLK = ~CLK;
    csd_decode dut (.CLK(CLK), .RST_N(RST_N), .START(START),
        .END_CYC(END_CYC), .WRITE(WRITE), .ADDR(ADDR), .ATTR(ATTR),
        .BYTE_EN(BYTE_EN), .SELECT_WINDOW_CONFIG(sw),
        .DRAM_WINDOW0_CONFIG(dw0), .DRAM_WINDOW1_CONFIG(dw1),
        .BUS_CLOCK_OUT(BUS_CLOCK_OUT), .ADDR_STROBE_N(ADDR_STROBE_N),
        .CS_N(CS_N), .BYTE_LANE_WRITE_ENABLES_N(BE_N), .OE_N(OE_N),
        .DRAM_SEL(DRAM_SEL), .CYC_CFG(CYC_CFG), .CYC_VALID(CYC_VALID));
    csd_peer peer (.clk(CLK), .rst_n(RST_N), .as_n(ADDR_STROBE_N),
        .wait_cyc(wt), .end_cyc(END_CYC));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic conclude();
        if (n_mismatch == 0 && checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // start a cycle and wait for the strobes
    task automatic go(input logic [31:0] a, input logic [3:0] at,
        input logic wr);
        @(posedge CLK);
        START <= 1'h1;
        ADDR <= a;
        ATTR <= at;
        WRITE <= wr;
        BYTE_EN <= a[3:0];
        @(posedge CLK);
        START <= 1'h0;
        #1;
        repeat (8) if (ADDR_STROBE_N !== 1'h0) @(posedge CLK) #1;
        check(ADDR_STROBE_N, 1'h0);
        check(BUS_CLOCK_OUT, 1'h0);
        check(OE_N, wr);
        if (wr) check(BE_N, {28'h0, ~a[3:0]});
    endtask
    task automatic done();
        repeat (20) if (CYC_VALID !== 1'h0) @(posedge CLK) #1;
        check(CYC_VALID, 1'h0);
    endtask
    task automatic t_single();
        for (int i = 0; i < 8; i++) begin
            wt <= i[3:0];
            go({i[7:0], 24'h000105}, 4'h0, i[0]);
            check(CS_N, {24'h0, ~(8'h1 << i)});
            check(DRAM_SEL, 2'h0);
            check({28'h0, CYC_CFG}, {28'h0, i[0], i[1], i[2:1]});
            done();
        end
    endtask
    task automatic t_none();
        go(32'h40000000, 4'h0, 1'h0);
        check({CS_N, DRAM_SEL, CYC_CFG}, 14'h3FC0);
        done();
        go(32'h00000200, 4'h1, 1'h1);
        check({CS_N, DRAM_SEL, CYC_CFG}, 14'h3FC0);
        done();
    endtask
    task automatic t_multi();
        @(posedge CLK);
        sw[1].base <= 32'h0;
        go(32'h00000010, 4'h0, 1'h0);
        check({CS_N, DRAM_SEL, CYC_CFG}, 14'h3F00);
        done();
        @(posedge CLK);
        sw[1].base <= 32'h01000000;
    endtask
    task automatic t_dram();
        for (int j = 0; j < 2; j++) begin
            go({4'h8 + j[3:0], 28'h0000303}, 4'h3, j[0]);
            check({CS_N, DRAM_SEL}, {8'hFF, 2'h1 << j});
            check(CYC_CFG, {j == 0, 1'h1,
                j == 0 ? csd_pkg::PORT_16 : csd_pkg::PORT_8});
            done();
        end
    endtask
    initial begin
        for (int i = 0; i < 8; i++)
            sw[i] = '{1'h1, {i[7:0], 24'h0}, 32'h00FFFFFF, 4'h0,
                i == 0 ? 4'hF : 4'h0, i[0], i[1], i[2:1]};
        // dram windows kept apart from each other and from selects
        dw0 = '{1'h1, 32'h80000000, 32'h00FFFFFF, 4'h0, 4'h0, 1'h1, 1'h1,
            csd_pkg::PORT_16};
        dw1 = '{1'h1, 32'h90000000, 32'h00FFFFFF, 4'h0, 4'h0, 1'h0, 1'h1,
            csd_pkg::PORT_8};
        repeat (6) @(posedge CLK);
        RST_N <= 1'h1;
        t_single();
        t_none();
        t_multi();
        t_dram();
        conclude();
    end
    initial begin
        #100000;
        n_mismatch++;
        conclude();
    end
endmodule
